// ---- hw/pssr_defs.svh ----
`ifndef PSSR_DEFS_SVH
`define PSSR_DEFS_SVH
// Register offsets
`define PSSR_OFS_PORT_EN 16'h3c48
`define PSSR_OFS_GLOBAL_EN 16'h4141
`define PSSR_OFS_P5_SEL 16'h416e
`define PSSR_OFS_P6_SEL 16'h416f
`define PSSR_OFS_TIMEOUT 16'h4171
`define PSSR_OFS_LOW_TIME 16'h4176
// Field positions
`define PSSR_BIT_PORT5 5
`define PSSR_BIT_PORT6 6
`define PSSR_BIT_GLOBAL 0
// Reset values
`define PSSR_RST_PORT_EN 8'h00
`define PSSR_RST_GLOBAL_EN 8'h00
`define PSSR_RST_SEL 8'h00
`define PSSR_RST_TIMEOUT 3'h5
`define PSSR_RST_LOW_TIME 8'h05
// Pin select codes
`define PSSR_P5_SEL_A 8'h42
`define PSSR_P5_SEL_B 8'h05
`define PSSR_P6_SEL_A 8'h06
`define PSSR_P6_SEL_B 8'h04
// Stuck link state range
`define PSSR_LINK_STUCK_LO 4'h4
`define PSSR_LINK_STUCK_HI 4'h9
// Timing
`define PSSR_CLK_PERIOD_NS 5
`define PSSR_MS_NS 1000000
`define PSSR_TO_1_MS 12'd100
`define PSSR_TO_2_MS 12'd250
`define PSSR_TO_3_MS 12'd500
`define PSSR_TO_4_MS 12'd750
`define PSSR_TO_5_MS 12'd1000
`define PSSR_TO_6_MS 12'd2000
`define PSSR_LOW_BASE_MS 12'd350
`define PSSR_LOW_STEP_MS 12'd10
`endif

// ---- hw/pssr_pkg.sv ----
package pssr_pkg;
    // Watchdog states, one-hot
    typedef enum logic [2:0] {
        PSSR_OFF = 3'b001,
        PSSR_WATCH = 3'b010,
        PSSR_LOW = 3'b100
    } pssr_state_t;
    // Register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } pssr_reg_req_t;
    // Pin bank: [0] p5 opt A, [1] p5 opt B, [2] p6 opt A, [3] p6 opt B
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] oe_n;
    } pssr_pins_t;
endpackage : pssr_pkg

// ---- hw/pssr_port_split.sv ----
`timescale 1ns/100ps
`include "pssr_defs.svh"

// Per-port link watchdog and power toggle
module pssr_port_wd #(
    parameter int MS_CYCLES = 200000
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Control
    input wire logic enable_in,
    input wire logic [3:0] link_state_in,
    input wire logic [11:0] timeout_ms_in,
    input wire logic [11:0] low_ms_in,
    // Status
    output logic power_out,
    output logic low_active_out
);
    import pssr_pkg::*;

    pssr_state_t state;
    pssr_state_t next_state;
    logic [17:0] cyc;
    logic [11:0] ms;
    logic [3:0] prev_link;
    logic stuck;
    logic ms_wrap;
    logic expired;
    logic low_done;

    ////////////////////////////////////////////////////////////////
    // Stuck detection
    // Judged from link state
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_link <= 4'h0;
        end else begin
            prev_link <= link_state_in;
        end
    end

    assign stuck = (link_state_in >= `PSSR_LINK_STUCK_LO) &&
                   (link_state_in <= `PSSR_LINK_STUCK_HI) &&
                   (link_state_in == prev_link);

    assign ms_wrap = (cyc == 18'(MS_CYCLES - 1));
    // Code zero never expires
    assign expired = (timeout_ms_in != 12'h000) && (ms == timeout_ms_in);
    assign low_done = (ms == low_ms_in);

    ////////////////////////////////////////////////////////////////
    // State machine
    // Watch while enabled
    always_comb begin
        next_state = state;
        case (state)
            PSSR_OFF: begin
                if (enable_in) begin
                    next_state = PSSR_WATCH;
                end
            end
            PSSR_WATCH: begin
                if (!enable_in) begin
                    next_state = PSSR_OFF;
                end else if (expired) begin
                    next_state = PSSR_LOW;
                end
            end
            PSSR_LOW: begin
                if (!enable_in) begin
                    next_state = PSSR_OFF;
                end else if (low_done) begin
                    next_state = PSSR_WATCH;
                end
            end
            default: begin
                next_state = PSSR_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= PSSR_OFF;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Per-port ms timer, private prescaler keeps timing exact
    // Clear and restart on expiry
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cyc <= 18'h00000;
            ms <= 12'h000;
        end else if (next_state != state) begin
            cyc <= 18'h00000;
            ms <= 12'h000;
        end else if (state == PSSR_WATCH && !stuck) begin
            // Any movement of the link restarts the wait
            cyc <= 18'h00000;
            ms <= 12'h000;
        end else if (state == PSSR_OFF) begin
            cyc <= 18'h00000;
            ms <= 12'h000;
        end else if (ms_wrap) begin
            cyc <= 18'h00000;
            ms <= ms + 12'h001;
        end else begin
            cyc <= cyc + 18'h00001;
        end
    end

    assign power_out = (state == PSSR_WATCH);
    assign low_active_out = (state == PSSR_LOW);
endmodule : pssr_port_wd

module pssr_port_split #(
    parameter int MS_CYCLES = `PSSR_MS_NS / `PSSR_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Register access
    input wire pssr_pkg::pssr_reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Link training state, ports 5 and 6
    input wire logic [3:0] link_state_p5_in,
    input wire logic [3:0] link_state_p6_in,
    // USB 2.0 port power, ports 5 and 6
    input wire logic [1:0] usb2_power_req_in,
    output logic [1:0] port_power_control_pin_out,
    // Split SuperSpeed power pins
    output pssr_pkg::pssr_pins_t split_superspeed_power_pin_out,
    // Status
    output logic [1:0] link_reset_active_out
);
    import pssr_pkg::*;

    logic [7:0] split_port_enable_mask;
    logic split_global_enable;
    logic [7:0] port5_split_pin_select;
    logic [7:0] port6_split_pin_select;
    logic [2:0] link_timeout_select;
    logic [7:0] link_reset_low_time;
    logic [11:0] timeout_ms;
    logic [11:0] low_ms;
    logic [1:0] port_en;
    logic [1:0] power;
    logic [1:0] low_active;
    logic [7:0] next_rdata;

    ////////////////////////////////////////////////////////////////
    // Register writes, settings come from the register access port
    // Loaded through access port
    // Only bits 5 and 6 stored
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            split_port_enable_mask <= `PSSR_RST_PORT_EN;
        end else if (reg_req_in.wr && reg_req_in.addr == `PSSR_OFS_PORT_EN) begin
            split_port_enable_mask <= 8'h00;
            split_port_enable_mask[`PSSR_BIT_PORT5] <= reg_req_in.wdata[`PSSR_BIT_PORT5];
            split_port_enable_mask[`PSSR_BIT_PORT6] <= reg_req_in.wdata[`PSSR_BIT_PORT6];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            split_global_enable <= 1'(`PSSR_RST_GLOBAL_EN);
        end else if (reg_req_in.wr && reg_req_in.addr == `PSSR_OFS_GLOBAL_EN) begin
            split_global_enable <= reg_req_in.wdata[`PSSR_BIT_GLOBAL];
        end
    end

    // Pin select registers
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port5_split_pin_select <= `PSSR_RST_SEL;
            port6_split_pin_select <= `PSSR_RST_SEL;
        end else if (reg_req_in.wr) begin
            if (reg_req_in.addr == `PSSR_OFS_P5_SEL) begin
                port5_split_pin_select <= reg_req_in.wdata;
            end
            if (reg_req_in.addr == `PSSR_OFS_P6_SEL) begin
                port6_split_pin_select <= reg_req_in.wdata;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_timeout_select <= `PSSR_RST_TIMEOUT;
        end else if (reg_req_in.wr && reg_req_in.addr == `PSSR_OFS_TIMEOUT) begin
            link_timeout_select <= reg_req_in.wdata[2:0];
        end
    end

    // Toggle low time code
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_reset_low_time <= `PSSR_RST_LOW_TIME;
        end else if (reg_req_in.wr && reg_req_in.addr == `PSSR_OFS_LOW_TIME) begin
            link_reset_low_time <= reg_req_in.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register reads, unmapped and reserved bits read zero
    always_comb begin
        next_rdata = 8'h00;
        case (reg_req_in.addr)
            `PSSR_OFS_PORT_EN: next_rdata = split_port_enable_mask;
            `PSSR_OFS_GLOBAL_EN: next_rdata = {7'h00, split_global_enable};
            `PSSR_OFS_P5_SEL: next_rdata = port5_split_pin_select;
            `PSSR_OFS_P6_SEL: next_rdata = port6_split_pin_select;
            `PSSR_OFS_TIMEOUT: next_rdata = {5'h00, link_timeout_select};
            `PSSR_OFS_LOW_TIME: next_rdata = link_reset_low_time;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_req_in.rd;
            if (reg_req_in.rd) begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Timing decode
    // Timeout code table
    always_comb begin
        case (link_timeout_select)
            3'h1: timeout_ms = `PSSR_TO_1_MS;
            3'h2: timeout_ms = `PSSR_TO_2_MS;
            3'h3: timeout_ms = `PSSR_TO_3_MS;
            3'h4: timeout_ms = `PSSR_TO_4_MS;
            3'h5: timeout_ms = `PSSR_TO_5_MS;
            3'h6: timeout_ms = `PSSR_TO_6_MS;
            // Reserved code treated as never, safer than a guess
            default: timeout_ms = 12'h000;
        endcase
    end

    // 350 ms plus 10 ms steps
    assign low_ms = `PSSR_LOW_BASE_MS + (`PSSR_LOW_STEP_MS * {4'h0, link_reset_low_time});

    assign port_en[0] = split_global_enable && split_port_enable_mask[`PSSR_BIT_PORT5];
    assign port_en[1] = split_global_enable && split_port_enable_mask[`PSSR_BIT_PORT6];

    ////////////////////////////////////////////////////////////////
    // Watchdogs for the two splittable ports
    pssr_port_wd #(
        .MS_CYCLES(MS_CYCLES)
    ) u_wd_p5 (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .enable_in(port_en[0]),
        .link_state_in(link_state_p5_in),
        .timeout_ms_in(timeout_ms),
        .low_ms_in(low_ms),
        .power_out(power[0]),
        .low_active_out(low_active[0])
    );

    pssr_port_wd #(
        .MS_CYCLES(MS_CYCLES)
    ) u_wd_p6 (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .enable_in(port_en[1]),
        .link_state_in(link_state_p6_in),
        .timeout_ms_in(timeout_ms),
        .low_ms_in(low_ms),
        .power_out(power[1]),
        .low_active_out(low_active[1])
    );

    ////////////////////////////////////////////////////////////////
    // Pin outputs
    // USB 2.0 power passes unchanged
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_power_control_pin_out <= 2'b00;
        end else begin
            port_power_control_pin_out <= usb2_power_req_in;
        end
    end

    // Output only, nothing sampled
    // An unknown select code leaves both pins of its own port undriven
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            split_superspeed_power_pin_out.level <= 4'h0;
            split_superspeed_power_pin_out.oe_n <= 4'hf;
        end else begin
            split_superspeed_power_pin_out.level <= {power[1], power[1], power[0], power[0]};
            split_superspeed_power_pin_out.oe_n[0] <=
                !(port_en[0] && port5_split_pin_select == `PSSR_P5_SEL_A);
            split_superspeed_power_pin_out.oe_n[1] <=
                !(port_en[0] && port5_split_pin_select == `PSSR_P5_SEL_B);
            split_superspeed_power_pin_out.oe_n[2] <=
                !(port_en[1] && port6_split_pin_select == `PSSR_P6_SEL_A);
            split_superspeed_power_pin_out.oe_n[3] <=
                !(port_en[1] && port6_split_pin_select == `PSSR_P6_SEL_B);
        end
    end

    // Toggle status for firmware
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_reset_active_out <= 2'b00;
        end else begin
            link_reset_active_out <= low_active;
        end
    end
endmodule : pssr_port_split

// ---- tb/pssr_dev_model.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Embedded SuperSpeed device hanging on a split power pin
module pssr_dev_model (
    // Clock
    input wire logic clk_sys_in,
    // Power and behaviour
    input wire logic power_in,
    input wire logic stuck_in,
    // Link training state seen by the hub
    output logic [3:0] link_state_out
);
    initial link_state_out = 4'h5;
    // Unpowered looks like receiver detect; stuck sits in polling
    // power follows pin
    always @(posedge clk_sys_in) begin
        if (!power_in) begin
            link_state_out <= 4'h5;
        end else if (stuck_in) begin
            link_state_out <= 4'h7;
        end else begin
            // Healthy link keeps moving, touching polling on purpose
            link_state_out <= (link_state_out == 4'h0) ? 4'h7 : 4'h0;
        end
    end
endmodule : pssr_dev_model

// ---- tb/pssr_port_split_chk.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
module pssr_port_split_chk
    import pssr_pkg::*;
#(
    parameter int MS_CYCLES = 200000
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Register access
    input wire pssr_reg_req_t reg_req_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    // Link and pins
    input wire logic [3:0] link_state_p5_in,
    input wire logic [3:0] link_state_p6_in,
    input wire logic [1:0] usb2_power_req_in,
    input wire logic [1:0] port_power_control_pin_out,
    input wire pssr_pins_t split_superspeed_power_pin_out,
    input wire logic [1:0] link_reset_active_out
);
    logic [7:0] mask, glob, sel5, sel6, lcode;
    logic [2:0] tcode;
    logic [3:0] prev5;
    logic en5, en6, stuck5;
    int scnt, acnt, to_cyc, lo_cyc;
    // Shadow of register writes
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {mask, glob, sel5, sel6} <= 32'h0;
            tcode <= 3'h5;
            lcode <= 8'h05;
        end else if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                16'h3c48: mask <= reg_req_in.wdata;
                16'h4141: glob <= reg_req_in.wdata;
                16'h416e: sel5 <= reg_req_in.wdata;
                16'h416f: sel6 <= reg_req_in.wdata;
                16'h4171: tcode <= reg_req_in.wdata[2:0];
                16'h4176: lcode <= reg_req_in.wdata;
                default: ;
            endcase
        end
    end
    // Expected spans in clocks
    always_comb begin
        case (tcode)
            3'h1: to_cyc = 100 * MS_CYCLES;
            3'h2: to_cyc = 250 * MS_CYCLES;
            3'h3: to_cyc = 500 * MS_CYCLES;
            3'h4: to_cyc = 750 * MS_CYCLES;
            3'h5: to_cyc = 1000 * MS_CYCLES;
            3'h6: to_cyc = 2000 * MS_CYCLES;
            default: to_cyc = 0;
        endcase
    end
    assign lo_cyc = (350 + 10 * int'(lcode)) * MS_CYCLES;
    assign en5 = glob[0] & mask[5];
    assign en6 = glob[0] & mask[6];
    assign stuck5 = (link_state_p5_in inside {[4'h4:4'h9]}) && (link_state_p5_in == prev5);
    // Stuck and low spans; stuck span cleared when off or low, as the watchdog counts stuck time only in watch
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev5 <= 4'h0;
            scnt <= 0;
            acnt <= 0;
        end else begin
            prev5 <= link_state_p5_in;
            scnt <= (link_reset_active_out[0] || !stuck5 || !en5) ? 0 : scnt + 1;
            acnt <= link_reset_active_out[0] ? acnt + 1 : 0;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    usb2_follow_a : assert property (
        1'b1 |=> port_power_control_pin_out == $past(usb2_power_req_in)) else $error("usb2 pin");
    rd_answer_a : assert property (
        reg_req_in.rd |=> reg_rvalid_out) else $error("no read answer");
    mask_resv_a : assert property (
        reg_req_in.rd && reg_req_in.addr == 16'h3c48 |=> (reg_rdata_out & 8'h9f) == 8'h00)
        else $error("mask reserved bits");
    glob_resv_a : assert property (
        reg_req_in.rd && reg_req_in.addr == 16'h4141 |=> reg_rdata_out[7:1] == 7'h00)
        else $error("global reserved bits");
    off_undriven_a : assert property (
        !en5 [*3] |-> &split_superspeed_power_pin_out.oe_n[1:0]) else $error("pin driven");
    pin_high_a : assert property (
        (en5 && sel5 == 8'h42 && !link_reset_active_out[0]) [*4] |->
        !split_superspeed_power_pin_out.oe_n[0] && split_superspeed_power_pin_out.level[0])
        else $error("port5 pin not high");
    p6_optb_a : assert property (
        (en6 && sel6 == 8'h04 && !link_reset_active_out[1]) [*4] |->
        !split_superspeed_power_pin_out.oe_n[3] && split_superspeed_power_pin_out.level[3])
        else $error("port6 pin not high");
    to_rise_a : assert property (
        $rose(link_reset_active_out[0]) |-> en5 && to_cyc != 0 && scnt >= to_cyc - 2
        && scnt <= to_cyc + 4) else $error("toggle at wrong time");
    low_drive_a : assert property (
        $rose(link_reset_active_out[0]) |=> split_superspeed_power_pin_out.level[1:0] == 2'b00)
        else $error("pin not low");
    low_len_a : assert property (
        $fell(link_reset_active_out[0]) && en5 |-> acnt >= lo_cyc - 1 && acnt <= lo_cyc + 2)
        else $error("low time wrong");
    // Main scenarios
    cover property ($rose(link_reset_active_out[0]));
    cover property (reg_req_in.rd && reg_req_in.addr == 16'h1234);
    cover property (en6 && !split_superspeed_power_pin_out.oe_n[3]);
endmodule : pssr_port_split_chk

bind pssr_port_split pssr_port_split_chk #(.MS_CYCLES(MS_CYCLES)) chk_i (
    .clk_sys_in, .rst_n_in, .reg_req_in, .reg_rdata_out, .reg_rvalid_out,
    .link_state_p5_in, .link_state_p6_in, .usb2_power_req_in,
    .port_power_control_pin_out, .split_superspeed_power_pin_out, .link_reset_active_out
);

// ---- tb/pssr_port_split_test.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
////////////////////////////////////////////////////////////
module pssr_port_split_test;
    import pssr_pkg::*;
    // Short millisecond keeps the run small
    localparam int MSC = 2;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    pssr_reg_req_t req = '0;
    logic [7:0] rdata;
    logic rvalid, stuck5 = 1'b1, stuck6 = 1'b1, pw5, pw6;
    logic [3:0] ls5, ls6;
    logic [1:0] usb2_req = 2'b00;
    logic [1:0] ppc, act;
    pssr_pins_t pins;
    int bad_count = 0;
    int n_checks = 0;
    int n;
    logic [15:0] ra [7] = '{16'h3c48, 16'h4141, 16'h416e, 16'h416f, 16'h4171, 16'h4176, 16'h1234};
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h05, 8'h00};
    initial begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    pssr_port_split #(.MS_CYCLES(MSC)) DUT (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .link_state_p5_in(ls5),
        .link_state_p6_in(ls6), .usb2_power_req_in(usb2_req),
        .port_power_control_pin_out(ppc), .split_superspeed_power_pin_out(pins),
        .link_reset_active_out(act)
    );
    // Undriven pin counts as unpowered
    assign pw5 = (!pins.oe_n[0] & pins.level[0]) | (!pins.oe_n[1] & pins.level[1]);
    assign pw6 = (!pins.oe_n[2] & pins.level[2]) | (!pins.oe_n[3] & pins.level[3]);
    pssr_dev_model dev5 (.clk_sys_in(clk_sys_in), .power_in(pw5), .stuck_in(stuck5),
        .link_state_out(ls5));
    pssr_dev_model dev6 (.clk_sys_in(clk_sys_in), .power_in(pw6), .stuck_in(stuck6),
        .link_state_out(ls6));
    ////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_in);
        #1;
    endtask : cyc
    // host configures over the register port
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        cyc(1);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        cyc(1);
        req = '0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        cyc(1);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        cyc(1);
        req = '0;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", e, rdata)
    endtask : rd
    task automatic wait_act(input int i, input logic v, input int lim);
        n = 0;
        while (act[i] !== v && n < lim) begin
            cyc(1);
            n++;
        end
    endtask : wait_act
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////
    // Watchdog, about three and a half times the expected run
    initial begin
        #60000;
        bad_count++;
        $display("watchdog expired");
        summarize();
    end
    initial begin
        cyc(3);
        rst_n_in = 1'b1;
        foreach (ra[i]) rd(ra[i], rv[i]);
        wr(16'h3c48, 8'hff);
        rd(16'h3c48, 8'h60);
        wr(16'h4141, 8'hff);
        rd(16'h4141, 8'h01);
        wr(16'h4171, 8'hff);
        rd(16'h4171, 8'h07);
        wr(16'h1234, 8'h5a);
        rd(16'h1234, 8'h00);
        wr(16'h4141, 8'h00);
        wr(16'h3c48, 8'h00);
        usb2_req = 2'b10;
        cyc(2);
        `CHK("usb2", 2'b10, ppc)
        `CHK("pins_off", 8'h0f, pins)
        $display("test registers done");
        wr(16'h416e, 8'h42);
        wr(16'h4171, 8'h01);
        wr(16'h4176, 8'h00);
        wr(16'h3c48, 8'h20);
        wr(16'h4141, 8'h01);
        cyc(3);
        `CHK("pin_high", 8'h3e, pins)
        wait_act(0, 1'b1, 2000);
        `CHK("t_rise", 1'b1, n inside {[195:212]})
        // Live switch to the 250 ms code while the pin is low
        wr(16'h4171, 8'h02);
        wait_act(0, 1'b0, 2000);
        `CHK("t_low", 1'b1, n inside {[695:703]})
        wait_act(0, 1'b1, 2000);
        `CHK("t_again", 1'b1, n inside {[498:512]})
        stuck5 = 1'b0;
        wait_act(0, 1'b0, 2000);
        wait_act(0, 1'b1, 600);
        `CHK("healthy", 600, n)
        $display("test watchdog done");
        wr(16'h4171, 8'h00);
        stuck5 = 1'b1;
        wr(16'h416f, 8'h04);
        wr(16'h3c48, 8'h60);
        wait_act(1, 1'b1, 600);
        `CHK("no_timeout", 600, n)
        `CHK("act", 2'b00, act)
        wr(16'h416e, 8'h05);
        cyc(3);
        `CHK("opt_b", 8'hf5, pins)
        wr(16'h4141, 8'h00);
        cyc(3);
        `CHK("global_off", 8'h0f, pins)
        $display("test options done");
        summarize();
    end
endmodule : pssr_port_split_test
